// ===== hw/ccr_defines.svh
// offsets, field positions, reset values and timing counts of the charger configuration bank
// Overview of operation
// - fast-charge register top bit enables pulse control
// - 7-bit fast-charge current, 64mA steps
// - all-zero fast-charge current code disables charging
// - fast-charge current codes above 0x4f clamp
// - charge voltage bits 7..2, default 010111
// - charge voltage codes above 110000 clamp
// - precharge exit threshold bit, default 3.0V
// - recharge offset bit, default 100mV below
// - one bit turns charge indicator pin off
// - 2-bit watchdog period: off/40/80/160 s
// - one bit enables safety timer, default on
// - 2-bit fast-charge duration, default 12 hrs
// - timer register bit 0 reserved, resets one
// - watchdog kick restarts timer, then bit clears
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// register offsets
`define CCR_OFS_FCC 8'h04
`define CCR_OFS_PTC 8'h05
`define CCR_OFS_CVC 8'h06
`define CCR_OFS_TTC 8'h07

// reset values
`define CCR_RST_FCC 8'h20
`define CCR_RST_PTC 8'h13
`define CCR_RST_CVC 8'h5e
`define CCR_RST_TTC 8'h9d

// clamp limits
`define CCR_FCC_MAX 7'h4f
`define CCR_CVL_MAX 6'h30

// field positions
`define CCR_FCC_PCE_BIT  7
`define CCR_PTC_PRE_LSB  4
`define CCR_CVC_CVL_LSB  2
`define CCR_CVC_THR_BIT  1
`define CCR_CVC_RCH_BIT  0
`define CCR_TTC_TERM_BIT 7
`define CCR_TTC_PIN_BIT  6
`define CCR_TTC_WD_LSB   4
`define CCR_TTC_TMR_BIT  3
`define CCR_TTC_DUR_LSB  1
`define CCR_TTC_RSV_BIT  0

// timing
`define CCR_CLK_HZ    40000000
`define CCR_WD_TICK_S 1
`define CCR_WD_40S    8'h28
`define CCR_WD_80S    8'h50
`define CCR_WD_160S   8'ha0

`endif

// ===== hw/ccr_pkg.sv
// types shared by the charger configuration bank
`default_nettype none
package ccr_pkg;

  // serial slave states, one-hot
  typedef enum logic [7:0] {
    CCR_IDLE = 8'h01,
    CCR_ADDR = 8'h02,
    CCR_AACK = 8'h04,
    CCR_PTR  = 8'h08,
    CCR_WR   = 8'h10,
    CCR_WACK = 8'h20,
    CCR_RD   = 8'h40,
    CCR_RACK = 8'h80
  } ccr_state_e;

  // main module state
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_f;
    logic       sda_f;
    ccr_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic       first;
    logic [7:0] ptr;
    logic [7:0] fcc;
    logic [7:0] ptc;
    logic [7:0] cvc;
    logic [7:0] ttc;
    logic       chg_dis;
    logic       wd_flag;  // registered watchdog expiry pulse
    logic       sda_o;
    logic       sda_oe;
  } ccr_top_s;

  // watchdog state
  typedef struct packed {
    logic [31:0] tick;
    logic [7:0]  secs;
    logic        expire;
    logic        kick_done;
  } ccr_wd_s;

endpackage
`default_nettype wire

// ===== hw/ccr_watchdog.sv
// host watchdog: counts seconds, restarts on kick, flags expiry
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_watchdog #(
  parameter int unsigned TICK_CYCLES = `CCR_CLK_HZ * `CCR_WD_TICK_S
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] period,
  input  wire logic       kick,
  output var  logic       expire,
  output var  logic       kick_done
);
  import ccr_pkg::*;

  ccr_wd_s q;  // registered state
  ccr_wd_s d;  // next state

  // period code to seconds
  function automatic logic [7:0] wd_limit(input logic [1:0] p);
    if (p == 2'b01) begin
      wd_limit = `CCR_WD_40S;
    end else if (p == 2'b10) begin
      wd_limit = `CCR_WD_80S;
    end else begin
      wd_limit = `CCR_WD_160S;
    end
  endfunction

  // next-state logic
  always_comb begin
    d = q;
    d.expire = 1'b0;
    d.kick_done = 1'b0;
    if (kick) begin
      // restart and tell the kick bit owner to clear it
      d.tick = 32'h0;
      d.secs = 8'h0;
      d.kick_done = 1'b1;
    end else if (period == 2'b00) begin
      // disabled: hold at zero
      d.tick = 32'h0;
      d.secs = 8'h0;
    end else if (q.tick == 32'(TICK_CYCLES - 1)) begin
      // one second elapsed
      d.tick = 32'h0;
      if (q.secs + 8'h1 >= wd_limit(period)) begin
        d.secs = 8'h0;
        d.expire = 1'b1;
      end else begin
        d.secs = q.secs + 8'h1;
      end
    end else begin
      d.tick = q.tick + 32'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;
  assign kick_done = q.kick_done;
endmodule
`default_nettype wire

// ===== hw/ccr_regs.sv
// charger configuration bank: serial slave, four config registers, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_regs #(
  parameter logic [6:0]  DEV_ADDR    = 7'h55,  // arbitrary bus address
  parameter int unsigned TICK_CYCLES = `CCR_CLK_HZ * `CCR_WD_TICK_S
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe,
  input  wire logic       reg_reset,
  input  wire logic       watchdog_kick,
  output var  logic       watchdog_kick_clear,
  output var  logic       watchdog_expired,
  output var  logic       pulse_control_enable,
  output var  logic [6:0] fast_charge_current,
  output var  logic       charge_disabled,
  output var  logic [3:0] precharge_current,
  output var  logic [3:0] termination_current,
  output var  logic [5:0] charge_voltage_limit,
  output var  logic       precharge_exit_threshold,
  output var  logic       recharge_offset,
  output var  logic       termination_enable,
  output var  logic       charge_indicator_pin_off,
  output var  logic [1:0] watchdog_period,
  output var  logic       safety_timer_enable,
  output var  logic [1:0] fast_charge_duration
);
  import ccr_pkg::*;

  ccr_top_s q;       // registered state
  ccr_top_s d;       // next state
  logic     wd_exp;  // watchdog expiry pulse
  logic     scl_n;   // filtered scl, next
  logic     sda_n;   // filtered sda, next
  logic     rise;    // scl rising edge
  logic     fall;    // scl falling edge
  logic     start;   // start condition
  logic     stop;    // stop condition
  logic     [7:0] rdb;  // read-back byte at the current pointer

  // read-back mux, unmapped reads as zero
  function automatic logic [7:0] rd_byte(input ccr_top_s s);
    if (s.ptr == `CCR_OFS_FCC) begin
      rd_byte = s.fcc;
    end else if (s.ptr == `CCR_OFS_PTC) begin
      rd_byte = s.ptc;
    end else if (s.ptr == `CCR_OFS_CVC) begin
      rd_byte = s.cvc;
    end else if (s.ptr == `CCR_OFS_TTC) begin
      rd_byte = s.ttc;
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // clamp a written fast-charge byte
  function automatic logic [7:0] fix_fcc(input logic [7:0] v);
    fix_fcc = v;
    if (v[6:0] > `CCR_FCC_MAX) begin
      fix_fcc[6:0] = `CCR_FCC_MAX;
    end
  endfunction

  // clamp a written charge voltage byte
  function automatic logic [7:0] fix_cvc(input logic [7:0] v);
    fix_cvc = v;
    if (v[7:`CCR_CVC_CVL_LSB] > `CCR_CVL_MAX) begin
      fix_cvc[7:`CCR_CVC_CVL_LSB] = `CCR_CVL_MAX;
    end
  endfunction

  // byte that a read would shift out next
  assign rdb = rd_byte(q);

  // host watchdog
  ccr_watchdog #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wd (
    .clk      (clk),
    .nrst     (nrst),
    .period   (q.ttc[`CCR_TTC_WD_LSB +: 2]),
    .kick     (watchdog_kick),
    .expire   (wd_exp),
    .kick_done(watchdog_kick_clear)
  );

  // pin filters and edge detection
  always_comb begin
    scl_n = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_f;
    sda_n = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_f;
    rise  = scl_n & ~q.scl_f;
    fall  = ~scl_n & q.scl_f;
    start = q.scl_f & scl_n & q.sda_f & ~sda_n;
    stop  = q.scl_f & scl_n & ~q.sda_f & sda_n;
  end

  // next-state logic
  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[1:0], scl_i};
    d.sda_sync = {q.sda_sync[1:0], sda_i};
    d.scl_f = scl_n;
    d.sda_f = sda_n;
    d.sda_o = 1'b0;
    if (start) begin
      // start or repeated start
      d.st = CCR_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      // stop ends any transfer
      d.st = CCR_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        CCR_ADDR, CCR_PTR, CCR_WR: begin
          // shift in a byte
          if (rise && q.bitcnt < 4'h8) begin
            d.shift = {q.shift[6:0], sda_n};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (fall && q.bitcnt == 4'h8) begin
            if (q.st == CCR_ADDR) begin
              if (q.shift[7:1] == DEV_ADDR) begin
                d.sda_oe = 1'b1;
                d.st = CCR_AACK;
              end else begin
                d.st = CCR_IDLE;
              end
            end else begin
              // acknowledge; store pointer or data
              d.sda_oe = 1'b1;
              d.st = CCR_WACK;
              if (q.st == CCR_PTR) begin
                d.ptr = q.shift;
              end else begin
                d.ptr = q.ptr + 8'h1;
                if (q.ptr == `CCR_OFS_FCC) begin
                  d.fcc = fix_fcc(q.shift);
                end else if (q.ptr == `CCR_OFS_PTC) begin
                  d.ptc = q.shift;
                end else if (q.ptr == `CCR_OFS_CVC) begin
                  d.cvc = fix_cvc(q.shift);
                end else if (q.ptr == `CCR_OFS_TTC) begin
                  d.ttc = q.shift;
                end
              end
            end
          end
        end
        CCR_AACK: begin
          // release ack; reads load first byte
          if (fall) begin
            d.bitcnt = 4'h0;
            if (q.shift[0]) begin
              d.shift = rdb;
              d.sda_oe = ~rdb[7];
              d.st = CCR_RD;
            end else begin
              d.sda_oe = 1'b0;
              d.st = CCR_PTR;
            end
          end
        end
        CCR_WACK: begin
          // release ack, more data bytes follow
          if (fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st = CCR_WR;
          end
        end
        CCR_RD: begin
          // shift a byte out, msb first
          if (rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (fall) begin
            if (q.bitcnt == 4'h8) begin
              d.sda_oe = 1'b0;
              d.ptr = q.ptr + 8'h1;
              d.st = CCR_RACK;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.sda_oe = ~q.shift[6];
            end
          end
        end
        CCR_RACK: begin
          // master ack continues, nack ends
          if (rise) begin
            d.first = sda_n;
          end else if (fall) begin
            d.bitcnt = 4'h0;
            if (!q.first) begin
              d.shift = rdb;
              d.sda_oe = ~rdb[7];
              d.st = CCR_RD;
            end else begin
              d.st = CCR_IDLE;
            end
          end
        end
        default: begin
          // idle: wait for start
          d.sda_oe = 1'b0;
          d.st = CCR_IDLE;
        end
      endcase
    end
    // defaults win over a write in the same cycle
    if (reg_reset || wd_exp) begin
      d.fcc = `CCR_RST_FCC;
      d.ptc = `CCR_RST_PTC;
      d.cvc = `CCR_RST_CVC;
      d.ttc = `CCR_RST_TTC;
    end
    d.chg_dis = (d.fcc[6:0] == 7'h00);
    // expiry indication registers on the same edge as the reload
    d.wd_flag = wd_exp;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.scl_sync <= 3'h7;
      q.sda_sync <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.st <= CCR_IDLE;
      q.fcc <= `CCR_RST_FCC;
      q.ptc <= `CCR_RST_PTC;
      q.cvc <= `CCR_RST_CVC;
      q.ttc <= `CCR_RST_TTC;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the registers
  assign watchdog_expired         = q.wd_flag;
  assign sda_o                    = q.sda_o;
  assign sda_oe                   = q.sda_oe;
  assign pulse_control_enable     = q.fcc[`CCR_FCC_PCE_BIT];
  assign fast_charge_current      = q.fcc[6:0];
  assign charge_disabled          = q.chg_dis;
  assign precharge_current        = q.ptc[`CCR_PTC_PRE_LSB +: 4];
  assign termination_current      = q.ptc[3:0];
  assign charge_voltage_limit     = q.cvc[`CCR_CVC_CVL_LSB +: 6];
  assign precharge_exit_threshold = q.cvc[`CCR_CVC_THR_BIT];
  assign recharge_offset          = q.cvc[`CCR_CVC_RCH_BIT];
  assign termination_enable       = q.ttc[`CCR_TTC_TERM_BIT];
  assign charge_indicator_pin_off = q.ttc[`CCR_TTC_PIN_BIT];
  assign watchdog_period          = q.ttc[`CCR_TTC_WD_LSB +: 2];
  assign safety_timer_enable      = q.ttc[`CCR_TTC_TMR_BIT];
  assign fast_charge_duration     = q.ttc[`CCR_TTC_DUR_LSB +: 2];
endmodule
`default_nettype wire

// ===== verification/ccr_regs_properties.sv
// port checker of the charger configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_regs_properties #(
  parameter logic [6:0]  DEV_ADDR    = 7'h55,
  parameter int unsigned TICK_CYCLES = `CCR_CLK_HZ * `CCR_WD_TICK_S
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       reg_reset,
  input wire logic       watchdog_kick,
  input wire logic       watchdog_kick_clear,
  input wire logic       watchdog_expired,
  input wire logic       pulse_control_enable,
  input wire logic [6:0] fast_charge_current,
  input wire logic       charge_disabled,
  input wire logic [3:0] precharge_current,
  input wire logic [3:0] termination_current,
  input wire logic [5:0] charge_voltage_limit,
  input wire logic       precharge_exit_threshold,
  input wire logic       recharge_offset,
  input wire logic       termination_enable,
  input wire logic       charge_indicator_pin_off,
  input wire logic [1:0] watchdog_period,
  input wire logic       safety_timer_enable,
  input wire logic [1:0] fast_charge_duration
);
  logic        at_dflt;       // every field at its reset value
  logic [31:0] since_kick_q;  // cycles since the last kick
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // all four registers compared against their defaults, except the reserved timer register bit 0
  assign at_dflt = {pulse_control_enable, fast_charge_current} == 8'h20
    && {precharge_current, termination_current} == 8'h13
    && {charge_voltage_limit, precharge_exit_threshold, recharge_offset} == 8'h5e
    && {termination_enable, charge_indicator_pin_off, watchdog_period, safety_timer_enable,
        fast_charge_duration} == 7'h4e;
  // kick age counter, bounds the earliest expiry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since_kick_q <= 32'h0;
    else if (watchdog_kick) since_kick_q <= 32'h0;
    else since_kick_q <= since_kick_q + 32'h1;
  end
  AST_CHG_OFF: assert property (charge_disabled == (fast_charge_current == 7'h00))
    else $error("charge off flag does not follow current code");
  AST_FCC_CLAMP: assert property (fast_charge_current <= 7'h4f)
    else $error("charge current code above clamp");
  AST_CVL_CLAMP: assert property (charge_voltage_limit <= 6'h30)
    else $error("charge voltage code above clamp");
  AST_KICK_CLR: assert property (watchdog_kick |=> watchdog_kick_clear)
    else $error("kick not cleared next cycle");
  AST_REG_RST: assert property (reg_reset |=> at_dflt)
    else $error("register reset left a field off default");
  AST_EXP_DFLT: assert property (watchdog_expired |-> at_dflt)
    else $error("expiry without defaults");
  AST_EXP_PULSE: assert property (watchdog_expired |=> !watchdog_expired)
    else $error("expiry pulse longer than one cycle");
  AST_WD_OFF: assert property (
    $past(watchdog_period, 2) == 2'b00 && $past(watchdog_period, 3) == 2'b00 |-> !watchdog_expired)
    else $error("expiry with watchdog off");
  AST_WD_MIN: assert property (watchdog_expired |-> since_kick_q >= 40 * TICK_CYCLES - 2)
    else $error("expiry sooner than shortest period");
  AST_SDA_LOW: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high while enabled");
  COV_EXPIRE: cover property (watchdog_expired);
  COV_RST: cover property (reg_reset ##1 at_dflt);
  COV_CHG_OFF: cover property ($rose(charge_disabled));
  COV_ACK: cover property ($rose(sda_oe));
endmodule
bind ccr_regs ccr_regs_properties #(.DEV_ADDR(DEV_ADDR), .TICK_CYCLES(TICK_CYCLES)) i_ccr_regs_properties (
  .clk, .nrst, .scl_i, .sda_i, .sda_o, .sda_oe, .reg_reset, .watchdog_kick, .watchdog_kick_clear,
  .watchdog_expired, .pulse_control_enable, .fast_charge_current, .charge_disabled, .precharge_current,
  .termination_current, .charge_voltage_limit, .precharge_exit_threshold, .recharge_offset,
  .termination_enable, .charge_indicator_pin_off, .watchdog_period, .safety_timer_enable,
  .fast_charge_duration);
`default_nettype wire

// ===== verification/ccr_host_model.sv
// host model: serial bus master driving the clock and pulling data low
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
  input  wire logic clk,
  input  wire logic sda_w,
  output var  logic scl,
  output var  logic sda_low
);
  localparam int PH = 8;  // clocks per half bit, above the filter minimum
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait n falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one line change per phase
  task automatic lvl(input logic c, input logic d);
    wt(PH);
    scl = c;
    sda_low = ~d;
  endtask
  // one bit; data moves two clocks after the clock fell, read mid high
  task automatic bit_x(input logic b, output logic v);
    wt(2);
    sda_low = ~b;
    wt(PH);
    scl = 1'b1;
    wt(PH / 2);
    v = sda_w;
    wt(PH / 2);
    scl = 1'b0;
  endtask
  // byte msb first, then the acknowledge slot released
  task automatic byte_x(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
    bit_x(1'b1, a);
    ack = ~a;
  endtask
  // start, also repeated start from a low clock
  task automatic st;
    lvl(1'b0, 1'b1);
    lvl(1'b1, 1'b1);
    lvl(1'b1, 1'b0);
    lvl(1'b0, 1'b0);
  endtask
  // pointer write then one data byte, or repeated start and one byte read
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, d, input logic rd,
                      output logic [7:0] q, output logic ok);
    logic k1, k2, k3, kn;
    st();
    byte_x({a, 1'b0}, q, k1);
    byte_x(p, q, k2);
    if (rd) begin
      st();
      byte_x({a, 1'b1}, q, k3);
      // own nack slot: the slave must have let go of the wire
      byte_x(8'hff, q, kn);
    end else begin
      byte_x(d, q, k3);
      kn = 1'b0;
    end
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b1, 1'b1);
    ok = k1 & k2 & k3 & ~kn;
  endtask
endmodule
`default_nettype wire

// ===== verification/ccr_regs_bench.sv
// bench: register traffic, clamps, resets and watchdog of the configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("BAD %s exp %h seen %h", nm, e, g); \
  end \
end
module ccr_regs_bench;
  localparam int          TICK = 10;  // watchdog second cut to 10 clocks
  localparam logic [7:0]  DFLT [4] = '{8'h20, 8'h13, 8'h5e, 8'h9d};  // reset values
  localparam logic [23:0] WT [8] = '{24'h048080, 24'h04ffcf, 24'h044f4f, 24'h05a5a5,
                                     24'h06ffc3, 24'h06c1c1, 24'h076262, 24'h04d0cf};  // ptr, wr, rd
  logic       clk, nrst, reg_reset, watchdog_kick, scl, sda_low, sda_oe, watchdog_expired;
  logic       pulse_control_enable, charge_disabled, precharge_exit_threshold, recharge_offset;
  logic       termination_enable, charge_indicator_pin_off, safety_timer_enable;
  logic [6:0] fast_charge_current;
  logic [5:0] charge_voltage_limit;
  logic [3:0] precharge_current, termination_current;
  logic [1:0] watchdog_period, fast_charge_duration;
  wire        sda_w = ~(sda_low | sda_oe);  // pulled-up data wire
  int         bad_count, num_checks, cyc, n, lim;
  ccr_regs #(.TICK_CYCLES(TICK)) i_ccr_regs (.clk, .nrst, .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe,
    .reg_reset, .watchdog_kick, .watchdog_kick_clear(), .watchdog_expired, .pulse_control_enable,
    .fast_charge_current, .charge_disabled, .precharge_current, .termination_current, .charge_voltage_limit,
    .precharge_exit_threshold, .recharge_offset, .termination_enable, .charge_indicator_pin_off,
    .watchdog_period, .safety_timer_enable, .fast_charge_duration);
  ccr_host_model i_ccr_host_model (.clk, .sda_w, .scl, .sda_low);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // register write, must be acknowledged
  task automatic wr(input logic [7:0] p, d);
    logic [7:0] q;
    logic       ok;
    i_ccr_host_model.xfer(7'h55, p, d, 1'b0, q, ok);
    `CHK("write ack", 1'b1, ok)
  endtask
  // register read against an expected byte
  task automatic rd(input logic [7:0] p, e);
    logic [7:0] q;
    logic       ok;
    i_ccr_host_model.xfer(7'h55, p, 8'h00, 1'b1, q, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK("read data", e, q)
  endtask
  task automatic rd_dflt;
    for (int i = 0; i < 4; i++) rd(8'h04 + 8'(i), DFLT[i]);
  endtask
  // main sequence
  initial begin
    logic [7:0] q;
    logic       ok;
    nrst = 1'b0;
    reg_reset = 1'b0;
    watchdog_kick = 1'b1;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd_dflt();
    `CHK("charge off", 1'b0, charge_disabled)
    for (int i = 0; i < 8; i++) begin
      wr(WT[i][23:16], WT[i][15:8]);
      rd(WT[i][23:16], WT[i][7:0]);
      if (WT[i][23:16] == 8'h04) `CHK("charge off", WT[i][6:0] == 7'h00, charge_disabled)
    end
    `CHK("pulse enable", 1'b1, pulse_control_enable)
    `CHK("charge current", 7'h4f, fast_charge_current)
    `CHK("precharge", 4'ha, precharge_current)
    `CHK("termination", 4'h5, termination_current)
    `CHK("voltage", 6'h30, charge_voltage_limit)
    `CHK("threshold", 1'b0, precharge_exit_threshold)
    `CHK("recharge", 1'b1, recharge_offset)
    `CHK("term enable", 1'b0, termination_enable)
    `CHK("pin off", 1'b1, charge_indicator_pin_off)
    `CHK("wd period", 2'b10, watchdog_period)
    `CHK("safety timer", 1'b0, safety_timer_enable)
    `CHK("duration", 2'b01, fast_charge_duration)
    i_ccr_host_model.xfer(7'h2a, 8'h04, 8'h00, 1'b0, q, ok);
    `CHK("foreign address ack", 1'b0, ok)
    rd(8'h04, 8'hcf);
    wr(8'h08, 8'h5a);
    rd(8'h08, 8'h00);
    @(negedge clk) reg_reset = 1'b1;
    @(negedge clk) reg_reset = 1'b0;
    rd_dflt();
    for (int p = 0; p < 4; p++) begin
      wr(8'h04, 8'h85);
      wr(8'h07, {2'b10, 2'(p), 4'hd});
      @(negedge clk) watchdog_kick = 1'b0;
      lim = (p == 0) ? 1700 : (40 * TICK) << (p - 1);
      n = 0;
      while (watchdog_expired !== 1'b1 && n < lim + 8) begin
        @(negedge clk);
        n++;
      end
      watchdog_kick = 1'b1;
      if (p == 0) `CHK("no expiry", 1'b0, watchdog_expired)
      else begin
        `CHK("expiry time", 1'b1, n >= lim - 3 && n <= lim + 5)
        rd(8'h04, 8'h20);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
